/* hw/actc_pkg.sv */
`default_nettype none
// ----------------------------------------
// Auxiliary channel threshold constants
// ----------------------------------------
package actc_pkg;
    // Register addresses
    localparam logic [7:0] ADDR_ADC_CONTROL      = 8'h3c;
    localparam logic [7:0] ADDR_TEMPERATURE_CTRL = 8'h3d;
    localparam logic [7:0] ADDR_ACT_THR_UPPER    = 8'h3e;
    localparam logic [7:0] ADDR_ACT_THR_LOWER    = 8'h3f;
    localparam logic [7:0] ADDR_INACT_THR_UPPER  = 8'h40;
    localparam logic [7:0] ADDR_INACT_THR_LOWER  = 8'h41;
    localparam logic [7:0] ADDR_AUX_TIMER        = 8'h42;
    // Reset values
    localparam logic [7:0] RST_ADC_CONTROL       = 8'hc0;
    localparam logic [7:0] RST_ZERO              = 8'h00;
    // Writable bit masks
    localparam logic [7:0] MASK_CONTROL          = 8'hcf;
    localparam logic [7:0] MASK_TEMP_CONTROL     = 8'h0f;
    localparam logic [7:0] MASK_THR_UPPER        = 8'h7f;
    localparam logic [7:0] MASK_THR_LOWER        = 8'hfc;
    localparam logic [7:0] MASK_TIMER            = 8'hff;
    // Field positions
    localparam int BIT_INACT_EN   = 3;
    localparam int BIT_ACT_EN     = 1;
    localparam int BIT_CONV_EN    = 0;
    localparam int FMT_MSB        = 7;
    localparam int FMT_LSB        = 6;
    // Read-out format codes
    localparam logic [1:0] FMT_STD12_ID = 2'h0;
    localparam logic [1:0] FMT_8BIT     = 2'h1;
    localparam logic [1:0] FMT_12BIT    = 2'h2;
    localparam logic [1:0] FMT_14_ID    = 2'h3;
    // Channel identifiers in the read-out word
    localparam logic [1:0] CHAN_ID_AUX  = 2'h3;
endpackage
`default_nettype wire

/* hw/actc_aux_threshold.sv */
`default_nettype none
module actc_aux_threshold
    import actc_pkg::*;
#(
    parameter int SAMPLE_W = 14,  // Signed sample width
    parameter int THRESH_W = 13   // Unsigned threshold width
) (
    input  wire logic                clk,           // Sample clock
    input  wire logic                reset,         // Async, active high
    input  wire logic                reg_wr,        // Register write strobe
    input  wire logic                reg_rd,        // Register read strobe
    input  wire logic [7:0]          reg_addr,      // Register address
    input  wire logic [7:0]          reg_wdata,     // Write data
    output logic      [7:0]          reg_rdata,     // Read data, registered
    input  wire logic                sample_tick,   // One pulse per output data rate
    input  wire logic [SAMPLE_W-1:0] aux_sample,    // Signed sample, valid on tick
    input  wire logic                fifo_rd,       // FIFO word read request
    input  wire logic [SAMPLE_W-1:0] fifo_word,     // Stored 14-bit word
    output logic      [15:0]         fifo_out,      // Formatted read-out word
    output logic                     temp_conv_en,  // Temperature conversion active
    output logic                     ext_conv_en,   // External converter active
    output logic                     temp_conv_req, // Temperature conversion pulse
    output logic                     aux_store,     // Store full sample pulse
    output logic      [SAMPLE_W-1:0] aux_store_data,// Full-width stored sample
    output logic                     activity_evt,  // Activity event pulse
    output logic                     inactivity_evt // Inactivity event pulse
);
    if (SAMPLE_W != 14 || THRESH_W != 13) begin : g_width_check
        $error("actc_aux_threshold supports only 14-bit samples, 13-bit thresholds");
    end

    // ----------------------------------------
    // Register file
    // ----------------------------------------
    logic [7:0] adc_control;                    // Format and external enables
    logic [7:0] temperature_control;            // Thermal enables
    logic [7:0] aux_activity_threshold_upper;   // High threshold [12:6]
    logic [7:0] aux_activity_threshold_lower;   // High threshold [5:0]
    logic [7:0] aux_inactivity_threshold_upper; // Low threshold [12:6]
    logic [7:0] aux_inactivity_threshold_lower; // Low threshold [5:0]
    logic [7:0] aux_timer;                      // Sample counts
    logic [7:0] next_adc_control;
    logic [7:0] next_temperature_control;
    logic [7:0] next_act_upper;
    logic [7:0] next_act_lower;
    logic [7:0] next_inact_upper;
    logic [7:0] next_inact_lower;
    logic [7:0] next_aux_timer;
    logic [7:0] next_reg_rdata;
    // Write decode with masks and read mux
    always_comb begin
        next_adc_control         = adc_control;
        next_temperature_control = temperature_control;
        next_act_upper           = aux_activity_threshold_upper;
        next_act_lower           = aux_activity_threshold_lower;
        next_inact_upper         = aux_inactivity_threshold_upper;
        next_inact_lower         = aux_inactivity_threshold_lower;
        next_aux_timer           = aux_timer;
        next_reg_rdata           = reg_rdata;
        if (reg_wr) begin
            case (reg_addr)
                // Reserved bits dropped on write
                ADDR_ADC_CONTROL:      next_adc_control = reg_wdata & MASK_CONTROL;
                ADDR_TEMPERATURE_CTRL: next_temperature_control = reg_wdata & MASK_TEMP_CONTROL;
                ADDR_ACT_THR_UPPER:    next_act_upper = reg_wdata & MASK_THR_UPPER;
                ADDR_ACT_THR_LOWER:    next_act_lower = reg_wdata & MASK_THR_LOWER;
                ADDR_INACT_THR_UPPER:  next_inact_upper = reg_wdata & MASK_THR_UPPER;
                ADDR_INACT_THR_LOWER:  next_inact_lower = reg_wdata & MASK_THR_LOWER;
                ADDR_AUX_TIMER:        next_aux_timer = reg_wdata & MASK_TIMER;
                default: ;              // Unmapped writes ignored
            endcase
        end
        if (reg_rd) begin
            case (reg_addr)
                ADDR_ADC_CONTROL:      next_reg_rdata = adc_control;
                ADDR_TEMPERATURE_CTRL: next_reg_rdata = temperature_control;
                ADDR_ACT_THR_UPPER:    next_reg_rdata = aux_activity_threshold_upper;
                ADDR_ACT_THR_LOWER:    next_reg_rdata = aux_activity_threshold_lower;
                ADDR_INACT_THR_UPPER:  next_reg_rdata = aux_inactivity_threshold_upper;
                ADDR_INACT_THR_LOWER:  next_reg_rdata = aux_inactivity_threshold_lower;
                ADDR_AUX_TIMER:        next_reg_rdata = aux_timer;
                default:               next_reg_rdata = RST_ZERO; // Unmapped reads zero
            endcase
        end
    end
    // Register storage
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            adc_control                    <= RST_ADC_CONTROL;
            temperature_control            <= RST_ZERO;
            aux_activity_threshold_upper   <= RST_ZERO;
            aux_activity_threshold_lower   <= RST_ZERO;
            aux_inactivity_threshold_upper <= RST_ZERO;
            aux_inactivity_threshold_lower <= RST_ZERO;
            aux_timer                      <= RST_ZERO;
            reg_rdata                      <= RST_ZERO;
        end else begin
            adc_control                    <= next_adc_control;
            temperature_control            <= next_temperature_control;
            aux_activity_threshold_upper   <= next_act_upper;
            aux_activity_threshold_lower   <= next_act_lower;
            aux_inactivity_threshold_upper <= next_inact_upper;
            aux_inactivity_threshold_lower <= next_inact_lower;
            aux_timer                      <= next_aux_timer;
            reg_rdata                      <= next_reg_rdata;
        end
    end
    // ----------------------------------------
    // Channel selection and compare
    // ----------------------------------------
    logic                temp_on;       // Thermal conversion requested
    logic                ext_on;        // External converter effective
    logic                act_on;        // Activity check armed
    logic                inact_on;      // Inactivity check armed
    logic [THRESH_W-1:0] act_thresh;    // Assembled high threshold
    logic [THRESH_W-1:0] inact_thresh;  // Assembled low threshold
    logic [SAMPLE_W-1:0] magnitude;     // Absolute sample value
    logic                above;         // Over high threshold
    logic                below;         // Under low threshold
    // Enables, assembled thresholds and magnitude compare
    always_comb begin
        temp_on  = temperature_control[BIT_CONV_EN];
        ext_on   = adc_control[BIT_CONV_EN] & ~temp_on;
        // Enables follow the channel in use
        act_on   = temp_on ? temperature_control[BIT_ACT_EN]
                           : (ext_on & adc_control[BIT_ACT_EN]);
        inact_on = temp_on ? temperature_control[BIT_INACT_EN]
                           : (ext_on & adc_control[BIT_INACT_EN]);
        act_thresh   = {aux_activity_threshold_upper[6:0],
                        aux_activity_threshold_lower[7:2]};
        inact_thresh = {aux_inactivity_threshold_upper[6:0],
                        aux_inactivity_threshold_lower[7:2]};
        magnitude = aux_sample[SAMPLE_W-1] ? SAMPLE_W'(-aux_sample) : aux_sample;
        // Raw code compare, no scaling
        above = magnitude > {1'b0, act_thresh};
        below = magnitude < {1'b0, inact_thresh};
    end

    // ----------------------------------------
    // Consecutive sample counters
    // ----------------------------------------
    logic [3:0] act_cnt;
    logic [3:0] inact_cnt;
    logic [3:0] next_act_cnt;
    logic [3:0] next_inact_cnt;
    logic       next_act_evt;
    logic       next_inact_evt;
    logic       next_store;
    logic       next_temp_req;
    logic [SAMPLE_W-1:0] next_store_data;
    logic [15:0] next_fifo_out;
    // Run lengths, sample store and read-out format
    always_comb begin
        next_act_cnt    = act_cnt;
        next_inact_cnt  = inact_cnt;
        next_act_evt    = 1'b0;
        next_inact_evt  = 1'b0;
        next_store      = 1'b0;
        next_temp_req   = 1'b0;
        next_store_data = aux_store_data;
        if (!act_on)
            next_act_cnt = 4'h0;
        if (!inact_on)
            next_inact_cnt = 4'h0;
        if (sample_tick) begin
            next_temp_req = temp_on;
            if (temp_on || ext_on) begin
                next_store      = 1'b1;
                next_store_data = aux_sample;
            end
            // Activity run length
            if (act_on) begin
                if (!above)
                    next_act_cnt = 4'h0;
                else if (act_cnt >= aux_timer[3:0]) begin
                    next_act_evt = 1'b1;
                    next_act_cnt = 4'h0;
                end else
                    next_act_cnt = act_cnt + 4'h1;
            end
            // Inactivity run length
            if (inact_on) begin
                if (!below)
                    next_inact_cnt = 4'h0;
                else if (inact_cnt >= aux_timer[7:4]) begin
                    next_inact_evt = 1'b1;
                    next_inact_cnt = 4'h0;
                end else
                    next_inact_cnt = inact_cnt + 4'h1;
            end
        end
        // Read-out formatting of stored word
        next_fifo_out = fifo_out;
        if (fifo_rd) begin
            case (adc_control[FMT_MSB:FMT_LSB])
                FMT_STD12_ID: next_fifo_out = {CHAN_ID_AUX, 2'h0, fifo_word[13:2]};
                FMT_8BIT:     next_fifo_out = {8'h00, fifo_word[13:6]};
                FMT_12BIT:    next_fifo_out = {4'h0, fifo_word[13:2]};
                FMT_14_ID:    next_fifo_out = {CHAN_ID_AUX, fifo_word};
                default:      next_fifo_out = 16'h0000;
            endcase
        end
    end
    // Counter and output registers
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            act_cnt        <= 4'h0;
            inact_cnt      <= 4'h0;
            activity_evt   <= 1'b0;
            inactivity_evt <= 1'b0;
            aux_store      <= 1'b0;
            aux_store_data <= '0;
            temp_conv_req  <= 1'b0;
            temp_conv_en   <= 1'b0;
            ext_conv_en    <= 1'b0;
            fifo_out       <= 16'h0000;
        end else begin
            act_cnt        <= next_act_cnt;
            inact_cnt      <= next_inact_cnt;
            activity_evt   <= next_act_evt;
            inactivity_evt <= next_inact_evt;
            aux_store      <= next_store;
            aux_store_data <= next_store_data;
            temp_conv_req  <= next_temp_req;
            temp_conv_en   <= temp_on;
            ext_conv_en    <= ext_on;
            fifo_out       <= next_fifo_out;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    property p_ext_block;
        @(posedge clk) disable iff (reset) temp_conv_en |-> !ext_conv_en;
    endproperty
    a_ext_block: assert property (p_ext_block) else $error("ext enabled with temp");
    property p_reset_ctl;
        @(posedge clk) $fell(reset) |-> adc_control == 8'hc0;
    endproperty
    a_reset_ctl: assert property (p_reset_ctl) else $error("control reset wrong");
    property p_rsvd;
        @(posedge clk) disable iff (reset)
            adc_control[5:4] == 2'h0 && temperature_control[7:4] == 4'h0
            && aux_activity_threshold_lower[1:0] == 2'h0;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bit set");
    property p_temp_req;
        @(posedge clk) disable iff (reset) sample_tick && temp_on |=> temp_conv_req;
    endproperty
    a_temp_req: assert property (p_temp_req) else $error("no temp conversion");
    property p_fmt8;
        @(posedge clk) disable iff (reset)
            fifo_rd && adc_control[7:6] == 2'h1 |=> fifo_out == {8'h00, $past(fifo_word[13:6])};
    endproperty
    a_fmt8: assert property (p_fmt8) else $error("8-bit format wrong");
    property p_fmt14;
        @(posedge clk) disable iff (reset)
            fifo_rd && adc_control[7:6] == 2'h3 |=> fifo_out[13:0] == $past(fifo_word);
    endproperty
    a_fmt14: assert property (p_fmt14) else $error("14-bit format wrong");
    property p_store;
        @(posedge clk) disable iff (reset)
            sample_tick && (temp_on || ext_on)
            |=> aux_store && aux_store_data == $past(aux_sample);
    endproperty
    a_store: assert property (p_store) else $error("sample not stored");
    property p_act_cause;
        @(posedge clk) disable iff (reset)
            activity_evt |-> $past(above) && $past(sample_tick) && $past(act_on);
    endproperty
    a_act_cause: assert property (p_act_cause) else $error("bad activity event");
    property p_inact_cause;
        @(posedge clk) disable iff (reset)
            inactivity_evt |-> $past(below) && $past(sample_tick) && $past(inact_on);
    endproperty
    a_inact_cause: assert property (p_inact_cause) else $error("bad inactivity");
    c_act:   cover property (@(posedge clk) disable iff (reset) activity_evt);
    c_inact: cover property (@(posedge clk) disable iff (reset) inactivity_evt);
    c_both:  cover property (@(posedge clk) disable iff (reset)
                 adc_control[0] && temperature_control[0]);
endmodule
`default_nettype wire

/* sim/actc_host_model.sv */
`default_nettype none
// ----------------------------------------
// Host processor on the register bus
// ----------------------------------------
module actc_host_model (
    input  wire logic       clk,       // Sample clock
    output logic            reg_wr,    // Write strobe
    output logic            reg_rd,    // Read strobe
    output logic      [7:0] reg_addr,  // Register address
    output logic      [7:0] reg_wdata, // Write data
    input  wire logic [7:0] reg_rdata  // Registered read data
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle bus, address lines parked on a pattern
    initial begin
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_addr  = 8'ha5;
        reg_wdata = 8'h5a;
    end
    // One write, held across one rising edge, then released with inverted lines
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_wr    = 1'b1;
        reg_addr  = a;
        reg_wdata = d;
        @(negedge clk);
        reg_wr    = 1'b0;
        reg_addr  = ~a;
        reg_wdata = ~d;
    endtask
    // One read, data taken once the registered answer has landed
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        reg_rd   = 1'b1;
        reg_addr = a;
        @(negedge clk);
        reg_rd   = 1'b0;
        reg_addr = ~a;
        @(negedge clk);
        d = reg_rdata;
    endtask
endmodule
`default_nettype wire

/* sim/actc_aux_threshold_bench.sv */
`default_nettype none
module actc_aux_threshold_bench
    import actc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic        clk, reset, reg_wr, reg_rd, sample_tick, fifo_rd;  // Drives and strobes
    logic        temp_conv_en, ext_conv_en, temp_conv_req, aux_store; // Conversion outputs
    logic        activity_evt, inactivity_evt;                       // Event pulses
    logic [7:0]  reg_addr, reg_wdata, reg_rdata;                     // Register bus
    logic [13:0] aux_sample, fifo_word, aux_store_data;              // Sample words
    logic [15:0] fifo_out;                                           // Formatted word
    int          err_total, n_tests;                                 // Counters
    // ----------------------------------------
    // Design and host
    // ----------------------------------------
    actc_aux_threshold actc_aux_threshold_i (.clk(clk), .reset(reset), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .sample_tick(sample_tick), .aux_sample(aux_sample), .fifo_rd(fifo_rd),
        .fifo_word(fifo_word), .fifo_out(fifo_out), .temp_conv_en(temp_conv_en),
        .ext_conv_en(ext_conv_en), .temp_conv_req(temp_conv_req), .aux_store(aux_store),
        .aux_store_data(aux_store_data), .activity_evt(activity_evt),
        .inactivity_evt(inactivity_evt));
    actc_host_model actc_host_model_i (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
    // Free-running 50 MHz clock
    always #10 clk = ~clk;
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        actc_host_model_i.wr(a, d);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        actc_host_model_i.rd(a, d);
        chk("reg_rdata", {8'h00, d}, {8'h00, exp});
    endtask
    // One sample tick; outputs are judged once the tick edge has landed
    task automatic tick(input logic [13:0] s);
        @(negedge clk);
        sample_tick = 1'b1;
        aux_sample  = s;
        @(negedge clk);
        sample_tick = 1'b0;
        aux_sample  = ~s;
    endtask
    task automatic ev(input logic [13:0] s, input logic act, input logic inact);
        tick(s);
        chk("activity_evt", 16'(activity_evt), 16'(act));
        chk("inactivity_evt", 16'(inactivity_evt), 16'(inact));
    endtask
    // Split a 13-bit threshold over its upper and lower registers
    task automatic set_thr(input logic [7:0] a, input logic [12:0] t);
        wr(a, {1'b0, t[12:6]});
        wr(a + 8'h01, {t[5:0], 2'b00});
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_regs();
        logic [7:0] mask [7] = '{8'hcf, 8'h0f, 8'h7f, 8'hfc, 8'h7f, 8'hfc, 8'hff};
        for (int i = 0; i < 7; i++) begin
            rd_chk(ADDR_ADC_CONTROL + 8'(i), (i == 0) ? 8'hc0 : 8'h00);
        end
        for (int i = 0; i < 7; i++) begin
            wr(ADDR_ADC_CONTROL + 8'(i), 8'hff);
            rd_chk(ADDR_ADC_CONTROL + 8'(i), mask[i]);
            wr(ADDR_ADC_CONTROL + 8'(i), (i == 0) ? 8'hc0 : 8'h00);
        end
        wr(8'h50, 8'hff);
        rd_chk(8'h50, 8'h00);
        rd_chk(ADDR_TEMPERATURE_CTRL, 8'h00);
    endtask
    task automatic t_format();
        logic [13:0] w = 14'h2a5b;
        logic [15:0] exp;
        for (int f = 0; f < 4; f++) begin
            wr(ADDR_ADC_CONTROL, {2'(f), 6'h00});
            case (f)
                0:       exp = {2'b11, 2'b00, w[13:2]};
                1:       exp = {8'h00, w[13:6]};
                2:       exp = {4'h0, w[13:2]};
                default: exp = {2'b11, w};
            endcase
            @(negedge clk);
            fifo_rd   = 1'b1;
            fifo_word = w;
            @(negedge clk);
            fifo_rd   = 1'b0;
            fifo_word = ~w;
            @(negedge clk);
            chk("fifo_out", fifo_out, exp);
        end
    endtask
    task automatic t_conv();
        wr(ADDR_ADC_CONTROL, 8'h01);
        repeat (2) @(negedge clk);
        chk("ext_conv_en", 16'(ext_conv_en), 16'h1);
        tick(14'h2001);
        chk("aux_store", 16'(aux_store), 16'h1);
        chk("aux_store_data", 16'(aux_store_data), 16'h2001);
        chk("temp_conv_req", 16'(temp_conv_req), 16'h0);
        wr(ADDR_TEMPERATURE_CTRL, 8'h01);
        repeat (2) @(negedge clk);
        chk("ext_conv_en", 16'(ext_conv_en), 16'h0);
        chk("temp_conv_en", 16'(temp_conv_en), 16'h1);
        tick(14'h1ffe);
        chk("temp_conv_req", 16'(temp_conv_req), 16'h1);
        chk("aux_store_data", 16'(aux_store_data), 16'h1ffe);
        wr(ADDR_TEMPERATURE_CTRL, 8'h00);
        wr(ADDR_ADC_CONTROL, 8'h00);
        tick(14'h0001);
        chk("temp_conv_req", 16'(temp_conv_req), 16'h0);
        chk("aux_store", 16'(aux_store), 16'h0);
    endtask
    task automatic t_events();
        set_thr(ADDR_ACT_THR_UPPER, 13'h0a5);
        set_thr(ADDR_INACT_THR_UPPER, 13'h0a5);
        wr(ADDR_ADC_CONTROL, 8'h03);
        ev(14'h3f5b, 1'b0, 1'b0);
        ev(14'h3f5a, 1'b1, 1'b0);
        ev(14'h00a6, 1'b1, 1'b0);
        wr(ADDR_AUX_TIMER, 8'h02);
        ev(14'h00a6, 1'b0, 1'b0);
        ev(14'h00a6, 1'b0, 1'b0);
        ev(14'h00a6, 1'b1, 1'b0);
        wr(ADDR_AUX_TIMER, 8'h00);
        wr(ADDR_ADC_CONTROL, 8'h01);
        ev(14'h00a6, 1'b0, 1'b0);
        wr(ADDR_ADC_CONTROL, 8'h09);
        ev(14'h00a4, 1'b0, 1'b1);
        ev(14'h00a5, 1'b0, 1'b0);
        ev(14'h3f5c, 1'b0, 1'b1);
        wr(ADDR_AUX_TIMER, 8'h10);
        ev(14'h00a4, 1'b0, 1'b0);
        ev(14'h00a4, 1'b0, 1'b1);
        wr(ADDR_AUX_TIMER, 8'h00);
        wr(ADDR_ADC_CONTROL, 8'h0b);
        wr(ADDR_TEMPERATURE_CTRL, 8'h01);
        ev(14'h00a6, 1'b0, 1'b0);
        wr(ADDR_TEMPERATURE_CTRL, 8'h03);
        ev(14'h00a6, 1'b1, 1'b0);
        wr(ADDR_TEMPERATURE_CTRL, 8'h09);
        ev(14'h00a4, 1'b0, 1'b1);
    endtask
    // Mid-run reset returns the control register to its default
    task automatic t_reset();
        wr(ADDR_ADC_CONTROL, 8'h0b);
        @(negedge clk);
        reset = 1'b1;
        @(negedge clk);
        reset = 1'b0;
        rd_chk(ADDR_ADC_CONTROL, 8'hc0);
        chk("ext_conv_en", 16'(ext_conv_en), 16'h0);
    endtask
    // ----------------------------------------
    // Verdict, watchdog and main sequence
    // ----------------------------------------
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // Whole run needs about 190 cycles; limit allows about thirteen times that
    initial begin
        repeat (2500) @(posedge clk);
        err_total++;
        report_and_stop();
    end
    initial begin
        clk         = 1'b0;
        reset       = 1'b1;
        sample_tick = 1'b0;
        fifo_rd     = 1'b0;
        aux_sample  = 14'h0000;
        fifo_word   = 14'h0000;
        err_total   = 0;
        n_tests     = 0;
        repeat (8) @(posedge clk);
        @(negedge clk);
        reset = 1'b0;
        t_regs();
        t_format();
        t_conv();
        t_events();
        t_reset();
        report_and_stop();
    end
endmodule
`default_nettype wire
